/* File: clamp_inhibit_pkg.sv */
/*
 * constants for the clamp inhibit timing and clock check register pair:
 * offsets, field positions, reset values and the activation code points.
 * assumes the frame decoder delivers 5-bit register addresses.
 */
package clamp_inhibit_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    localparam logic [ADDR_W-1:0] TIMING_ADDR = 5'h1e;
    localparam logic [ADDR_W-1:0] CHECK_ADDR  = 5'h1f;

    localparam int unsigned FIELD_HI   = 15;
    localparam int unsigned FIELD_LO   = 8;
    localparam int unsigned LMI_BIT    = 1;
    localparam int unsigned PARITY_BIT = 0;
    localparam int unsigned RSVD_W     = 6;

    localparam logic [DATA_W-1:0] TIMING_RESET = 16'h2600;
    localparam logic [DATA_W-1:0] CHECK_RESET  = 16'h0001;

    localparam logic [7:0] AT_CONST_HIGH = 8'h00;
    localparam logic [7:0] AT_CONST_LOW  = 8'hff;
    localparam logic [7:0] AT_MIN_TIMED  = 8'h0a;

    typedef enum logic [1:0] {
        PULSE_IDLE   = 2'b00,
        PULSE_ACTIVE = 2'b01
    } pulse_state_t;

endpackage : clamp_inhibit_pkg

/* File: clamp_inhibit_timing_regs.sv */
/*
 * clamp inhibit timing register and clock check register, with the
 * invalid-frame flag and odd parity returned in every read word of the two registers.
 * assumes a frame decoder on ref_clk that presents one decoded frame per
 * req_valid pulse and flags framing or checksum errors on req_error.
 */
// Functional notes
// (RULE1) activation field sets inhibit pulse length
// (RULE2) codes 0x0a..0xfe timed; 0x01..0x09 reserved
// (RULE3) code 0x00 holds inhibit output high
// (RULE4) code 0xff holds inhibit output low
// (RULE5) bits 7..2 always read as zero
// (RULE6) bit 1 reports previous frame discarded
// (RULE7) bit 0 is odd parity of word
// (RULE8) clock check count written by hardware only
// (RULE9) host ignores clock check register contents
// (RULE10) timing writes only in config mode
`timescale 1ns/1ps
`default_nettype none

module clamp_inhibit_timing_regs
    import clamp_inhibit_pkg::*;
(
    input  wire logic              ref_clk,           // 40 MHz clock
    input  wire logic              arst_n,            // async reset, low
    input  wire logic              req_valid,         // frame strobe
    input  wire logic              req_write,         // 1 long write, 0 read
    input  wire logic [ADDR_W-1:0] req_addr,          // register address
    input  wire logic [DATA_W-1:0] req_wdata,         // write word
    input  wire logic              req_error,         // frame is corrupt
    input  wire logic              config_mode,       // config mode active
    input  wire logic              switch_trigger,    // start inhibit pulse
    input  wire logic              meas_valid,        // clock check done
    input  wire logic [7:0]        meas_count,        // measured osc cycles
    output logic                   resp_valid,        // read word ready
    output logic                   resp_hit,          // address mapped here
    output logic [DATA_W-1:0]      resp_data,         // read word
    output logic                   clamp_inhibit_out  // clamp inhibit pin
);

    logic [7:0] act_cycles_q;
    logic [7:0] meas_count_q;
    logic       last_msg_invalid_q;

    // parity bit that makes the whole word carry an odd number of ones
    function automatic logic odd_parity(input logic [DATA_W-1:1] upper);
        odd_parity = ~(^upper);
    endfunction : odd_parity

    function automatic logic [DATA_W-1:0] pack_word(input logic [7:0] field,
                                                    input logic       last_msg_invalid);
        logic [DATA_W-1:1] upper;
        upper = {field, {RSVD_W{1'b0}}, last_msg_invalid};                   // [RULE5]
        pack_word = {upper, odd_parity(upper)};                  // [RULE7]
    endfunction : pack_word

    // reserved activation codes are refused so the timer never sees them
    function automatic logic at_legal(input logic [7:0] code);
        at_legal = (code == AT_CONST_HIGH) || (code >= AT_MIN_TIMED);
    endfunction : at_legal

    wire       sel_timing = (req_addr == TIMING_ADDR);
    wire       sel_check  = (req_addr == CHECK_ADDR);
    wire       mapped     = sel_timing || sel_check;
    wire [7:0] wr_field   = req_wdata[FIELD_HI:FIELD_LO];

    wire wr_accept = req_valid && req_write && sel_timing && !req_error
                     && config_mode                              // [RULE10]
                     && at_legal(wr_field);                      // [RULE2]

    // writes to the clock check word, out-of-mode and reserved writes drop
    wire wr_refused = req_write && mapped && !wr_accept;
    wire discard    = req_valid && (req_error || wr_refused);

    wire [DATA_W-1:0] timing_word = pack_word(act_cycles_q,
                                              last_msg_invalid_q);
    wire [DATA_W-1:0] check_word  = pack_word(meas_count_q,
                                              last_msg_invalid_q);
    wire [DATA_W-1:0] read_word   = sel_timing ? timing_word :
                                    sel_check  ? check_word  :
                                    {DATA_W{1'b0}};
    wire              read_req    = req_valid && !req_write;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            act_cycles_q <= TIMING_RESET[FIELD_HI:FIELD_LO];
        end else if (wr_accept) begin
            act_cycles_q <= wr_field;                            // [RULE1]
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meas_count_q <= CHECK_RESET[FIELD_HI:FIELD_LO];
        end else if (meas_valid) begin
            meas_count_q <= meas_count;                          // [RULE8]
        end
    end

    // flag follows every frame so it always describes the previous one
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_msg_invalid_q <= TIMING_RESET[LMI_BIT];
        end else if (req_valid) begin
            last_msg_invalid_q <= discard;                       // [RULE6]
        end
    end

    // reads are served in every mode; the word carries the old flag
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            resp_valid <= 1'b0;
            resp_hit   <= 1'b0;
            resp_data  <= {DATA_W{1'b0}};
        end else begin
            resp_valid <= read_req;                              // [RULE10]
            resp_hit   <= read_req && mapped;
            if (read_req) begin
                resp_data <= read_word;                          // [RULE6]
            end
        end
    end

    clamp_pulse_gen u_pulse (
        .ref_clk           (ref_clk),
        .arst_n            (arst_n),
        .trigger           (switch_trigger),
        .act_cycles        (act_cycles_q),
        .clamp_inhibit_out (clamp_inhibit_out)
    );

endmodule : clamp_inhibit_timing_regs

`default_nettype wire

/* File: clamp_inhibit_timing_regs_tb.sv */
/* bench for the clamp timing register pair: frames via the host model,
   expected read words queued and compared by a monitor at negedge. */
`timescale 1ns/1ps
`default_nettype none
module clamp_inhibit_timing_regs_tb;
    import clamp_inhibit_pkg::*;
    logic ref_clk, arst_n, config_mode, switch_trigger, meas_valid, clamp;
    logic req_valid, req_write, req_error, resp_valid, resp_hit, prev_bad;
    logic [7:0]  meas_count, fld, mc, n;
    logic [4:0]  req_addr;
    logic [15:0] req_wdata, resp_data;
    logic [16:0] exp_q[$];
    int failures, samples_checked, cycles, seed, k;
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    frame_host i_host (.ref_clk(ref_clk), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_error(req_error));
    clamp_inhibit_timing_regs i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_error(req_error),
        .config_mode(config_mode), .switch_trigger(switch_trigger),
        .meas_valid(meas_valid), .meas_count(meas_count),
        .resp_valid(resp_valid), .resp_hit(resp_hit),
        .resp_data(resp_data), .clamp_inhibit_out(clamp));
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [16:0] word(input logic [7:0] f);
        return {1'b1, f, 6'h00, prev_bad, ~^{f, prev_bad}};
    endfunction : word
    task automatic fr(input logic w, input logic [4:0] a,
                      input logic [7:0] f, input logic e);
        logic bad;
        bad = e || w && (a == CHECK_ADDR || a == TIMING_ADDR &&
            (!config_mode || f inside {[8'h01:8'h09]}));
        if (!w) exp_q.push_back(a == TIMING_ADDR ? word(fld) :
            (a == CHECK_ADDR ? word(mc) : 17'h00000));
        i_host.frame(w, a, {f, 8'h5a}, e);
        if (w && !bad && a == TIMING_ADDR) fld = f;
        prev_bad = bad;
    endtask : fr
    task automatic pin(input logic e);
        repeat (3) @(negedge ref_clk);
        chk({16'h0000, clamp}, {16'h0000, e});
    endtask : pin
    task automatic pulse();
        @(negedge ref_clk);
        switch_trigger = 1'b1;
        @(negedge ref_clk);
        switch_trigger = 1'b0;
        k = 0;
        repeat (int'(fld) + 4) begin
            k += int'(clamp === 1'b1);
            @(negedge ref_clk);
        end
        // a code held constant low must give no pulse at all
        chk(17'(k), (fld == AT_CONST_LOW) ? 17'h00000 : {9'h000, fld});
    endtask : pulse
    task automatic wrap_up();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    always @(negedge ref_clk) begin
        if (resp_valid === 1'b1)
            chk({resp_hit, resp_data}, exp_q.pop_front());
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        {arst_n, switch_trigger, meas_valid, prev_bad} = 4'h0;
        {seed, config_mode, meas_count, mc} = {32'd94005, 17'h10000};
        fld = TIMING_RESET[15:8];
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        fr(0, TIMING_ADDR, 0, 0);
        fr(0, CHECK_ADDR, 0, 0);
        fr(0, 5'h05, 0, 0);
        for (n = 8'h01; n < 8'h0a; n++) fr(1, TIMING_ADDR, n, 0);
        fr(0, TIMING_ADDR, 0, 0);
        fr(1, TIMING_ADDR, AT_MIN_TIMED, 0);
        pulse();
        config_mode = 1'b0;
        fr(1, TIMING_ADDR, 8'h00, 0);
        fr(0, TIMING_ADDR, 0, 0);
        config_mode = 1'b1;
        fr(1, TIMING_ADDR, 8'h00, 1);
        fr(1, TIMING_ADDR, AT_CONST_HIGH, 0);
        pin(1'b1);
        fr(1, TIMING_ADDR, AT_CONST_LOW, 0);
        pulse();
        @(negedge ref_clk);
        meas_count = 8'($random(seed));
        meas_valid = 1'b1;
        @(negedge ref_clk);
        meas_valid = 1'b0;
        mc = meas_count;
        fr(1, CHECK_ADDR, 8'h55, 0);
        fr(0, CHECK_ADDR, 0, 1);
        fr(0, TIMING_ADDR, 0, 0);
        repeat (6) begin
            n = 8'h0a + 8'({$random(seed)} % 245);
            fr(1, TIMING_ADDR, n, 0);
            pulse();
        end
        wrap_up();
    end
endmodule : clamp_inhibit_timing_regs_tb
`default_nettype wire

/* File: clamp_pulse_gen.sv */
/*
 * timed clamp inhibit output driven from the activation field.
 * assumes ref_clk is the secondary oscillator clock and that the trigger
 * is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module clamp_pulse_gen
    import clamp_inhibit_pkg::*;
(
    input  wire logic       ref_clk,           // secondary oscillator clock
    input  wire logic       arst_n,            // async reset, active low
    input  wire logic       trigger,           // start of a timed activation
    input  wire logic [7:0] act_cycles,        // activation field value
    output logic            clamp_inhibit_out  // registered inhibit output
);

    pulse_state_t state_q;
    pulse_state_t state_d;
    logic [7:0]   count_q;
    logic [7:0]   count_d;
    logic         out_d;

    wire force_high = (act_cycles == AT_CONST_HIGH);
    wire force_low  = (act_cycles == AT_CONST_LOW);
    wire timed_mode = !force_high && !force_low;

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            PULSE_IDLE: begin
                if (trigger && timed_mode) begin
                    state_d = PULSE_ACTIVE;
                    count_d = act_cycles - 8'h01;  // [RULE1]
                end
            end
            PULSE_ACTIVE: begin
                // a forced mode written mid-pulse ends the pulse at once
                if (!timed_mode || count_q == 8'h00) begin
                    state_d = PULSE_IDLE;
                end else begin
                    count_d = count_q - 8'h01;
                end
            end
            default: begin
                state_d = PULSE_IDLE;
                count_d = 8'h00;
            end
        endcase
    end

    always_comb begin
        if (force_high) begin
            out_d = 1'b1;                          // [RULE3]
        end else if (force_low) begin
            out_d = 1'b0;                          // [RULE4]
        end else begin
            out_d = (state_d == PULSE_ACTIVE);     // [RULE1] [RULE2]
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q           <= PULSE_IDLE;
            count_q           <= 8'h00;
            clamp_inhibit_out <= 1'b0;
        end else begin
            state_q           <= state_d;
            count_q           <= count_d;
            clamp_inhibit_out <= out_d;
        end
    end

endmodule : clamp_pulse_gen

`default_nettype wire

/* File: clamp_regs_chk.sv */
/* assertions on the ports of the clamp timing register pair.
   assumes one clock and an async low reset; bound below. */
`timescale 1ns/1ps
`default_nettype none
module clamp_regs_chk
    import clamp_inhibit_pkg::*;
(
    input wire logic              ref_clk,           // clock
    input wire logic              arst_n,            // reset
    input wire logic              req_valid,         // frame
    input wire logic              req_write,         // write
    input wire logic [ADDR_W-1:0] req_addr,          // address
    input wire logic [DATA_W-1:0] req_wdata,         // word
    input wire logic              req_error,         // corrupt
    input wire logic              config_mode,       // config
    input wire logic              switch_trigger,    // trigger
    input wire logic              resp_valid,        // answer
    input wire logic              resp_hit,          // mapped
    input wire logic [DATA_W-1:0] resp_data,         // read word
    input wire logic              clamp_inhibit_out  // inhibit
);
    logic [7:0] fld_q;
    logic [7:0] cnt_q;
    logic       bad_q;
    wire rd  = req_valid && !req_write;
    wire bad = req_error || req_write && (req_addr == CHECK_ADDR ||
        req_addr == TIMING_ADDR && (!config_mode ||
        req_wdata[15:8] inside {[8'h01:8'h09]}));
    wire tmd = fld_q >= AT_MIN_TIMED && fld_q != AT_CONST_LOW;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fld_q <= TIMING_RESET[15:8];
            bad_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            if (req_valid && req_write && !bad && req_addr == TIMING_ADDR)
                fld_q <= req_wdata[15:8];
            if (req_valid)
                bad_q <= bad;
            cnt_q <= clamp_inhibit_out ? cnt_q + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_start;
        !clamp_inhibit_out && switch_trigger && tmd ##1 tmd;
    endsequence
    a_pulse_start: assert property (s_start |-> clamp_inhibit_out)
        else $error("timed pulse did not start");
    a_pulse_len: assert property ($fell(clamp_inhibit_out) && tmd &&
        $stable(fld_q) |-> cnt_q == fld_q) else $error("pulse length");
    a_force_high: assert property ((fld_q == AT_CONST_HIGH)[*2] |->
        clamp_inhibit_out) else $error("inhibit not held high");
    a_force_low: assert property ((fld_q == AT_CONST_LOW)[*2] |->
        !clamp_inhibit_out) else $error("inhibit not held low");
    a_read_answer: assert property (resp_valid == $past(rd))
        else $error("read answer timing");
    a_word_format: assert property (resp_valid && resp_hit |->
        ^resp_data && resp_data[7:2] == 6'h00) else $error("word format");
    a_flag_report: assert property (resp_valid |->
        resp_data[LMI_BIT] == $past(bad_q)) else $error("invalid flag");
    a_field_read: assert property (resp_valid && resp_hit &&
        $past(req_addr) == TIMING_ADDR |-> resp_data[15:8] == $past(fld_q))
        else $error("activation field");
endmodule : clamp_regs_chk
bind clamp_inhibit_timing_regs clamp_regs_chk i_chk (.*);
`default_nettype wire

/* File: frame_host.sv */
/* host model: hands one decoded frame per call to the register pair.
   assumes it shares ref_clk with the block and drives at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module frame_host
    import clamp_inhibit_pkg::*;
(
    input  wire logic              ref_clk,   // clock
    output logic                   req_valid, // frame strobe
    output logic                   req_write, // write select
    output logic [ADDR_W-1:0]      req_addr,  // address
    output logic [DATA_W-1:0]      req_wdata, // word
    output logic                   req_error  // corrupt frame
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr  = 5'h00;
        req_wdata = 16'h0000;
        req_error = 1'b0;
    end
    task automatic frame(input logic w, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, input logic e);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr  = a;
        req_wdata = d;
        req_error = e;
        @(negedge ref_clk);
        req_valid = 1'b0;
        // stale address and data are inverted so a late sample cannot match
        req_addr  = ~a;
        req_wdata = ~d;
    endtask : frame
endmodule : frame_host
`default_nettype wire
